// ### gex_pkg.sv
package gex_pkg;

  // Slave address, low bit replaced by the address-select strap
  localparam logic [6:0] SLV_ADDR_BASE = 7'h20;
  localparam int         BIT_RW        = 0;

  // Register selector codes
  localparam logic [7:0] REG_IN  = 8'h00;
  localparam logic [7:0] REG_OUT = 8'h01;
  localparam logic [7:0] REG_INV = 8'h02;
  localparam logic [7:0] REG_DIR = 8'h03;

  // Reset values
  localparam logic [7:0] RST_OUT = 8'hFF;
  localparam logic [7:0] RST_INV = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_PTR = 8'h00;

  // Bits per serial byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR       = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD       = 7'h20,
    ST_RD_ACK   = 7'h40
  } gex_state_e;

  // Software-visible port configuration
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] invert;
    logic [7:0] dir;
  } gex_regs_s;

  localparam gex_regs_s REGS_RST = '{latch: RST_OUT, invert: RST_INV,
                                     dir: RST_DIR};

endpackage

// ### gex_expander.sv
`timescale 1ns/10ps
// Overview of operation
// RQ1: The first byte after an acknowledged write address loads the pointer.
// RQ2: The master sends the selector byte only in write transactions.
// RQ3: Selector 00 is input levels, 01 latch, 02 inversion mask, 03 direction.
// RQ4: The pointer can be written and also read back over the serial bus; the code returns it only when it holds a value above 03.
// RQ5: Register 0 reads the present level of every pin, input or output.
// RQ6: Writes aimed at register 0 change nothing at all.
// RQ7: Register 0 has no reset value and simply follows the pin levels.
// RQ8: The master loads the pointer with a write before reading levels.
// RQ9: Latch bits drive output pins only, and reset to all ones.
// RQ10: Reading the latch returns its flip-flops, not the pin levels.
// RQ11: A set mask bit inverts an input pin's reported level; resets to zero.
// RQ12: Direction 1 makes a pin a released input, 0 an output; resets to ones.
// RQ13: The slave address is 0x20 with the strap low and 0x21 with it high.
// RQ14: Address byte bit 0 set means read, clear means write.
// RQ15: The pointer is kept between transactions.
// RQ16: Reset restores pointer, latch, mask and direction and idles the bus.
module gex_expander
  import gex_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       addr_sel,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] pin_in,
  output logic [7:0]      pin_out,
  output logic [7:0]      pin_oe
);

  // Bit 7 of each pin bus is expander_pin_top, bit 0 expander_pin_bottom

  gex_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic       ptr_pend_q, ptr_pend_d;
  logic       rw_q, rw_d;
  logic       sda_oe_q, sda_oe_d;
  gex_regs_s  regs_q, regs_d;
  logic       scl_q, sda_q;
  logic [7:0] pin_smp_q;
  logic [7:0] pin_out_q, pin_out_d;
  logic [7:0] pin_oe_q, pin_oe_d;
  logic       sda_out_q;
  logic       scl_rise, scl_fall, start_cond, stop_cond;
  logic       addr_hit, rd_load, byte_done;
  logic [7:0] rd_byte;

  // Reported input levels after the polarity mask
  function automatic logic [7:0] input_view(logic [7:0] lvl, gex_regs_s r);
    return lvl ^ (r.invert & r.dir); // RQ11
  endfunction

  // Read data selected by the pointer
  function automatic logic [7:0] read_mux(logic [7:0] ptr, gex_regs_s r,
                                          logic [7:0] lvl);
    unique case (ptr) // RQ3
      REG_IN:  return input_view(lvl, r); // RQ5
      REG_OUT: return r.latch; // RQ10
      REG_INV: return r.invert;
      REG_DIR: return r.dir;
      default: return ptr; // RQ4
    endcase
  endfunction

  // Bus events; pins are sampled once so both edges see one value
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
  assign byte_done  = scl_fall & (cnt_q == BYTE_BITS);
  assign addr_hit   = shift_q[7:1] == {SLV_ADDR_BASE[6:1], addr_sel}; // RQ13
  assign rd_load    = scl_fall & (((state_q == ST_ADDR_ACK) & rw_q) |
                                  (state_q == ST_RD_ACK));
  assign rd_byte    = read_mux(ptr_q, regs_q, pin_smp_q);

  // Serial engine and register writes
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    shift_d    = shift_q;
    ptr_d      = ptr_q; // RQ15
    ptr_pend_d = ptr_pend_q;
    rw_d       = rw_q;
    sda_oe_d   = sda_oe_q;
    regs_d     = regs_q;
    if (start_cond) begin
      // Repeated start is legal anywhere and restarts address reception
      state_d  = ST_ADDR;
      cnt_d    = CNT_ZERO;
      sda_oe_d = 1'b0;
    end else if (stop_cond) begin
      state_d  = ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise && cnt_q != BYTE_BITS) begin
            shift_d = {shift_q[6:0], sda_in};
            cnt_d   = cnt_q + CNT_ONE;
          end else if (byte_done && state_q == ST_ADDR) begin
            if (addr_hit) begin
              state_d    = ST_ADDR_ACK;
              sda_oe_d   = 1'b1;
              rw_d       = shift_q[BIT_RW]; // RQ14
              ptr_pend_d = 1'b1;
            end else begin
              state_d = ST_IDLE; // Not ours: stay off the bus
            end
          end else if (byte_done) begin
            state_d  = ST_WR_ACK;
            sda_oe_d = 1'b1;
            if (ptr_pend_q) begin
              ptr_d      = shift_q; // RQ1
              ptr_pend_d = 1'b0;
            end else begin
              unique case (ptr_q) // RQ3
                REG_OUT: regs_d.latch  = shift_q;
                REG_INV: regs_d.invert = shift_q;
                REG_DIR: regs_d.dir    = shift_q;
                default: regs_d        = regs_q; // RQ6
              endcase
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK, ST_RD_ACK: begin
          if (state_q == ST_RD_ACK && scl_rise && sda_in) begin
            state_d = ST_IDLE; // Master NACK ends the read
          end else if (rd_load) begin
            state_d  = ST_RD;
            shift_d  = {rd_byte[6:0], 1'b0};
            cnt_d    = CNT_ONE;
            sda_oe_d = ~rd_byte[7];
          end else if (scl_fall && state_q != ST_RD_ACK) begin
            state_d  = ST_WR;
            cnt_d    = CNT_ZERO;
            sda_oe_d = 1'b0;
          end
        end
        ST_RD: begin
          if (byte_done) begin
            state_d  = ST_RD_ACK;
            sda_oe_d = 1'b0;
          end else if (scl_fall) begin
            // Open drain: pull low for a zero, release for a one
            sda_oe_d = ~shift_q[7];
            shift_d  = {shift_q[6:0], 1'b0};
            cnt_d    = cnt_q + CNT_ONE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q    <= ST_IDLE; // RQ16
      cnt_q      <= CNT_ZERO;
      shift_q    <= 8'h00;
      ptr_q      <= RST_PTR;
      ptr_pend_q <= 1'b0;
      rw_q       <= 1'b0;
      sda_oe_q   <= 1'b0;
      regs_q     <= REGS_RST; // RQ9 RQ11 RQ12
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      shift_q    <= shift_d;
      ptr_q      <= ptr_d;
      ptr_pend_q <= ptr_pend_d;
      rw_q       <= rw_d;
      sda_oe_q   <= sda_oe_d;
      regs_q     <= regs_d;
      scl_q      <= scl_in;
      sda_q      <= sda_in;
    end
  end

  // Pin levels are never reset, so they read whatever is driven
  always_ff @(posedge core_clk) begin
    pin_smp_q <= pin_in; // RQ7
  end

  // Pin drivers follow latch and direction one cycle later
  always_comb begin
    pin_out_d = regs_q.latch; // RQ9
    pin_oe_d  = ~regs_q.dir; // RQ12
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_out_q <= RST_OUT;
      pin_oe_q  <= ~RST_DIR;
      sda_out_q <= 1'b0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
      sda_out_q <= 1'b0;
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe  = sda_oe_q;
  assign pin_out = pin_out_q;
  assign pin_oe  = pin_oe_q;

  // Serial engine checks
  a_ptr_capture: assert property ( // RQ1
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_WR && ptr_pend_q && byte_done && !start_cond && !stop_cond
    |=> ptr_q == $past(shift_q) && state_q == ST_WR_ACK && sda_oe_q)
    else $error("pointer not loaded from first write byte");

  a_input_write_ignored: assert property ( // RQ6
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_WR && !ptr_pend_q && ptr_q == REG_IN && byte_done
    |=> $stable(regs_q) && $stable(ptr_q))
    else $error("write to input register changed state");

  a_dir_to_pins: assert property ( // RQ12
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_WR && !ptr_pend_q && ptr_q == REG_DIR && byte_done
    && !start_cond && !stop_cond
    |=> ##1 pin_oe_q == ~$past(shift_q, 2))
    else $error("direction write did not reach pin enables");

  a_latch_readback: assert property ( // RQ10
    @(posedge core_clk) disable iff (!nrst)
    rd_load && ptr_q == REG_OUT
    |=> state_q == ST_RD && sda_oe_q == ~$past(regs_q.latch[7]))
    else $error("latch read returned wrong first bit");

  a_level_readback: assert property ( // RQ5
    @(posedge core_clk) disable iff (!nrst)
    rd_load && ptr_q == REG_IN
    |=> sda_oe_q == $past(~(pin_smp_q[7] ^
                            (regs_q.invert[7] & regs_q.dir[7]))))
    else $error("input level read returned wrong first bit");

  a_addr_miss_quiet: assert property ( // RQ13
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_ADDR && byte_done && !addr_hit
    |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("foreign address was acknowledged");

  a_stop_to_idle: assert property ( // RQ15
    @(posedge core_clk) disable iff (!nrst)
    stop_cond |=> state_q == ST_IDLE && !sda_oe_q && $stable(ptr_q))
    else $error("stop did not idle the engine");

  // The address acknowledge must still be pulled low a cycle later
  a_read_direction: assert property ( // RQ14
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_ADDR && byte_done && addr_hit
    |=> rw_q == $past(shift_q[0]) ##1 sda_oe_q[*1])
    else $error("direction bit not captured");

  a_write_ack_release: assert property ( // RQ1
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_WR_ACK && scl_fall
    |=> state_q == ST_WR && !sda_oe_q && cnt_q == CNT_ZERO)
    else $error("write acknowledge not released on clock fall");

  a_ptr_readback: assert property ( // RQ4
    @(posedge core_clk) disable iff (!nrst)
    rd_load && ptr_q > REG_DIR
    |=> state_q == ST_RD && sda_oe_q == ~$past(ptr_q[7]))
    else $error("pointer readback returned wrong first bit");

  // Register file and pin driver checks
  a_latch_write: assert property ( // RQ9
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_WR && !ptr_pend_q && ptr_q == REG_OUT && byte_done
    |=> regs_q.latch == $past(shift_q) && $stable(regs_q.dir))
    else $error("latch write did not land");

  a_mask_write: assert property ( // RQ11
    @(posedge core_clk) disable iff (!nrst)
    state_q == ST_WR && !ptr_pend_q && ptr_q == REG_INV && byte_done
    |=> regs_q.invert == $past(shift_q) && $stable(regs_q.latch))
    else $error("inversion mask write did not land");

  a_pins_track: assert property ( // RQ9
    @(posedge core_clk) disable iff (!nrst)
    $changed(regs_q.latch)
    |=> pin_out_q == $past(regs_q.latch))
    else $error("pin levels did not follow the latch");

  a_pin_oe_track: assert property ( // RQ12
    @(posedge core_clk) disable iff (!nrst)
    $changed(regs_q.dir)
    |=> pin_oe_q == ~$past(regs_q.dir))
    else $error("pin enables did not follow the direction");

  // Checked without the reset disable, since reset is the trigger
  a_reset_defaults: assert property ( // RQ16
    @(posedge core_clk)
    !nrst |=> state_q == ST_IDLE && ptr_q == RST_PTR && regs_q == REGS_RST
    && !sda_oe_q && pin_out_q == RST_OUT && pin_oe_q == ~RST_DIR)
    else $error("reset did not restore the defaults");

endmodule

// ### gex_master_model.sv
`timescale 1ns/10ps
// Bus master model; both lines pulled up, so a released line reads high
module gex_master_model (
  input  wire logic core_clk,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  output logic      scl_line,
  output logic      sda_line
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // Wired AND of master and device on SDA
  assign scl_line = scl_q;
  assign sda_line = sda_q & (sda_oe ? sda_out : 1'b1);
  // One change per 3-cycle step keeps SDA clear of SCL edges
  task automatic put(input logic s, input logic c);
    repeat (3) @(posedge core_clk);
    #1;
    sda_q = s;
    scl_q = c;
  endtask
  // Also serves as repeated start
  task automatic start();
    put(1'b1, scl_q);
    put(1'b1, 1'b1);
    put(1'b0, 1'b1);
    put(1'b0, 1'b0);
  endtask
  task automatic stop();
    put(1'b0, 1'b0);
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic [8:0] v;
    logic [8:0] r;
    v = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      put(v[i], 1'b0);
      put(v[i], 1'b1);
      repeat (3) @(posedge core_clk);
      r[i] = sda_line;
      put(v[i], 1'b0);
    end
    {rx, ack_out} = r;
  endtask
endmodule

// ### gex_expander_test.sv
`timescale 1ns/10ps
module gex_expander_test;
  import gex_pkg::*;
  logic       core_clk;
  logic       nrst;
  logic       addr_sel;
  logic       scl_in;
  logic       sda_in;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] ext;
  logic [7:0] ptr_m;
  gex_regs_s  m;
  int         num_errors;
  int         num_checks;
  // Driven pins show the latch, released pins the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  gex_expander gex_expander_inst (.core_clk(core_clk), .nrst(nrst),
    .addr_sel(addr_sel), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  gex_master_model gex_master_model_inst (.core_clk(core_clk),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_line(scl_in),
    .sda_line(sda_in));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, seen, exp);
    end
  endtask
  // Expected read data from the register model and the pins
  function automatic logic [7:0] exp_rd();
    logic [7:0] pins;
    pins = (~m.dir & m.latch) | (m.dir & ext);
    case (ptr_m)
      REG_IN:  return pins ^ (m.invert & m.dir);
      REG_OUT: return m.latch;
      REG_INV: return m.invert;
      REG_DIR: return m.dir;
      default: return ptr_m;
    endcase
  endfunction
  // Address plus write bit, then the pointer byte; tracks the pointer
  task automatic sel_ptr(input logic [7:0] p);
    logic [7:0] rx;
    logic       a;
    gex_master_model_inst.start();
    gex_master_model_inst.xfer({SLV_ADDR_BASE[6:1], addr_sel, 1'b0},
                               1'b1, rx, a);
    check({7'h00, a}, 8'h00, "write address ack");
    gex_master_model_inst.xfer(p, 1'b1, rx, a);
    check({7'h00, a}, 8'h00, "pointer ack");
    ptr_m = p;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] rx;
    logic       a;
    sel_ptr(p);
    gex_master_model_inst.xfer(d, 1'b1, rx, a);
    check({7'h00, a}, 8'h00, "data ack");
    gex_master_model_inst.stop();
    if (p == REG_OUT) m.latch = d;
    if (p == REG_INV) m.invert = d;
    if (p == REG_DIR) m.dir = d;
  endtask
  // Optional pointer write, repeated start, n bytes read, NACK, stop
  task automatic rd(input logic w, input logic [7:0] p, input int n);
    logic [7:0] rx;
    logic       a;
    if (w) sel_ptr(p);
    gex_master_model_inst.start();
    gex_master_model_inst.xfer({SLV_ADDR_BASE[6:1], addr_sel, 1'b1},
                               1'b1, rx, a);
    check({7'h00, a}, 8'h00, "read address ack");
    for (int i = 0; i < n; i++) begin
      gex_master_model_inst.xfer(8'hFF, i == n - 1, rx, a);
      check(rx, exp_rd(), "read data");
    end
    gex_master_model_inst.stop();
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    m = '{latch: 8'hFF, invert: 8'h00, dir: 8'hFF};
    ptr_m = 8'h00;
    check(pin_out, 8'hFF, "latch reset");
    check(pin_oe, 8'h00, "direction reset");
    rd(1'b0, 8'h00, 1);
  endtask
  // Watchdog sized well above the expected run of about 29k cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
  initial begin
    logic [7:0] rx;
    logic       a;
    void'($urandom(32'h9C74F1F3));
    num_errors = 0;
    num_checks = 0;
    addr_sel = 1'b0;
    ext = 8'($urandom);
    do_reset();
    for (int p = 1; p < 4; p++) rd(1'b1, 8'(p), 1);
    $display("test reset done");
    // Right strap answers, the other address stays silent
    for (int s = 0; s < 2; s++) begin
      addr_sel = s[0];
      wr(REG_DIR, 8'hFF);
      gex_master_model_inst.start();
      gex_master_model_inst.xfer({SLV_ADDR_BASE[6:1], ~s[0], 1'b0},
                                 1'b1, rx, a);
      check({7'h00, a}, 8'h01, "foreign address");
      gex_master_model_inst.stop();
    end
    $display("test address done");
    for (int k = 0; k < 6; k++) begin
      ext = 8'($urandom);
      wr(REG_OUT, 8'($urandom));
      wr(REG_INV, 8'($urandom));
      wr(REG_DIR, k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($urandom));
      check(pin_out, m.latch, "pin level");
      check(pin_oe, ~m.dir, "pin drive");
      for (int p = 0; p < 4; p++) rd(1'b1, 8'(p), 2);
    end
    $display("test random done");
    wr(REG_IN, ~ext);
    check(pin_oe, ~m.dir, "pins after input write");
    for (int p = 0; p < 4; p++) rd(1'b1, 8'(p), 1);
    $display("test input write done");
    for (int v = 0; v < 3; v++) begin
      wr(v == 0 ? 8'h04 : v == 1 ? 8'h7E : 8'hFF, 8'h5A);
      rd(1'b0, 8'h00, 2);
    end
    $display("test pointer done");
    wr(REG_OUT, 8'h00);
    wr(REG_DIR, 8'h00);
    do_reset();
    for (int p = 1; p < 4; p++) rd(1'b1, 8'(p), 1);
    $display("test second reset done");
    close_out();
  end
endmodule
